/* tb/tb.sv */
// Purpose: Register-level bench for the FIFO control block
// Assumes: Far model feeds the receive side, drains the transmit side
// Notes: Reads sample one cycle after the strobe
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) \
  begin n_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb;
  import ufc_pkg::*;
  logic mclk, rst, reg_wr, reg_rd, tx_pop, tx_valid, rx_push, rx_space;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, tx_data, rx_char, v, w;
  logic tx_dma_ready_n, rx_dma_ready_n, irq, pop_en, push_req;
  int error_cnt, n_checks, i, k;
  logic [6:0] trg [8] = '{7'h01, 7'h04, 7'h08, 7'h0e,
                          7'h01, 7'h10, 7'h20, 7'h38};
  ufc_fifo_ctrl dut_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .tx_pop, .tx_valid, .tx_data, .rx_push, .rx_char,
    .rx_space, .tx_dma_ready_n, .rx_dma_ready_n, .irq);
  ufc_far_model far_u (.mclk, .rst, .pop_en, .push_req, .tx_valid, .tx_pop,
    .rx_push, .rx_char);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  task automatic bound(input int n, input int lim);
    if (n >= lim)
    begin
      error_cnt++;
      wrap_up();
    end
  endtask : bound
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task automatic push1;
    @(posedge mclk);
    push_req <= 1'b1;
    @(posedge mclk);
    push_req <= 1'b0;
    repeat (2) @(posedge mclk);
    #1;
  endtask : push1
  // Let the model pop until the transmit side runs dry
  task automatic drain;
    pop_en = 1'b1;
    for (i = 0; i < 200 && tx_valid !== 1'b0; i++)
    begin
      @(posedge mclk);
      #1;
    end
    pop_en = 1'b0;
    bound(i, 200);
  endtask : drain
  initial
  begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    pop_en = 1'b0;
    push_req = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    rd(ADDR_CTRL, v);
    `CHK(v, 8'h00)
    `CHK({tx_dma_ready_n, rx_dma_ready_n}, 2'b01)
    rd(3'h1, v);
    `CHK(v, 8'h00)
    wr(3'h3, 8'hff);
    rd(3'h3, v);
    `CHK(v, 8'h00)
    wr(ADDR_IRQ_MASK, 8'h03);
    wr(ADDR_HOLD, 8'ha5);
    #1;
    `CHK({tx_dma_ready_n, tx_valid, tx_data}, 10'h3a5)
    drain;
    `CHK(tx_dma_ready_n, 1'b0)
    rd(ADDR_IRQ_STAT, v);
    `CHK({v, irq}, 9'h005)
    wr(ADDR_IRQ_STAT, 8'h03);
    rd(ADDR_IRQ_STAT, v);
    `CHK({v, irq}, 9'h000)
    push1;
    `CHK({rx_dma_ready_n, irq}, 2'b01)
    push1;
    rd(ADDR_RX_LEVEL, v);
    `CHK(v, 8'h01)
    rd(ADDR_HOLD, v);
    `CHK({v, rx_dma_ready_n}, 9'h083)
    wr(ADDR_CTRL, 8'hff);
    rd(ADDR_CTRL, v);
    `CHK(v, 8'he9)
    // Every trigger code in both depths, mode 1
    for (k = 0; k < 8; k++)
    begin
      wr(ADDR_CTRL, {k[1:0], k[2], 5'h0b});
      wr(ADDR_IRQ_STAT, 8'h03);
      for (i = 1; i < trg[k]; i++) push1;
      `CHK(rx_dma_ready_n, 1'b1)
      push1;
      `CHK(rx_dma_ready_n, 1'b0)
      rd(ADDR_IRQ_STAT, v);
      `CHK(v[0], 1'b1)
    end
    wr(ADDR_CTRL, 8'h0b);
    for (i = 0; i < 40 && rx_space; i++) push1;
    bound(i, 40);
    rd(ADDR_RX_LEVEL, v);
    `CHK({v, rx_space}, 9'h020)
    `CHK(rx_dma_ready_n, 1'b0)
    wr(ADDR_CTRL, 8'h0b);
    #1;
    `CHK({rx_dma_ready_n, rx_space}, 2'b11)
    for (i = 0; i < 16; i++)
    begin
      #1;
      `CHK(tx_dma_ready_n, 1'b0)
      wr(ADDR_HOLD, i[7:0]);
    end
    #1;
    `CHK(tx_dma_ready_n, 1'b1)
    rd(ADDR_TX_LEVEL, v);
    `CHK(v, 8'h10)
    wr(ADDR_IRQ_STAT, 8'h03);
    rd(ADDR_IRQ_STAT, v);
    `CHK(v[1], 1'b0)
    drain;
    `CHK(tx_dma_ready_n, 1'b0)
    rd(ADDR_IRQ_STAT, v);
    `CHK(v[1], 1'b1)
    wr(ADDR_IRQ_MASK, 8'h00);
    rd(ADDR_IRQ_STAT, v);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 8'h02);
    rd(ADDR_IRQ_STAT, v);
    `CHK(irq, 1'b1)
    wr(ADDR_HOLD, 8'h5a);
    wr(ADDR_CTRL, 8'h0d);
    rd(ADDR_TX_LEVEL, v);
    `CHK(v, 8'h00)
    rd(ADDR_CTRL, v);
    `CHK(v, 8'h09)
    // FIFOs on in mode 0: ready pins follow any stored character
    wr(ADDR_CTRL, 8'h07);
    push1;
    push1;
    rd(ADDR_RX_LEVEL, v);
    `CHK({v, rx_dma_ready_n}, 9'h004)
    rd(ADDR_HOLD, w);
    rd(ADDR_HOLD, v);
    `CHK(v, w + 8'h01)
    `CHK(rx_dma_ready_n, 1'b1)
    wr(ADDR_HOLD, 8'h11);
    wr(ADDR_HOLD, 8'h22);
    rd(ADDR_TX_LEVEL, v);
    `CHK({v, tx_dma_ready_n}, 9'h005)
    `CHK({tx_valid, tx_data}, 9'h111)
    drain;
    `CHK(tx_dma_ready_n, 1'b0)
    wrap_up();
  end
endmodule : tb
`default_nettype wire

/* tb/ufc_far_model.sv */
// Purpose: Serialiser and receiver stand-in for the FIFO block
// Assumes: Shares mclk with the block
// Notes: Pops at half rate so the transmit FIFO drains slowly
`timescale 1ns/10ps
`default_nettype none
module ufc_far_model
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Bench control
  input wire logic pop_en,
  input wire logic push_req,
  // Block side
  input wire logic tx_valid,
  output logic tx_pop,
  output logic rx_push,
  output logic [7:0] rx_char
);
  logic [7:0] next_q;
  // Idle data shows the inverse, so a stale char never looks fresh
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_pop <= 1'b0;
      rx_push <= 1'b0;
      rx_char <= 8'h00;
      next_q <= 8'h41;
    end
    else
    begin
      tx_pop <= pop_en && tx_valid && !tx_pop;
      rx_push <= push_req;
      rx_char <= push_req ? next_q : ~rx_char;
      next_q <= next_q + {7'h00, push_req};
    end
  end
endmodule : ufc_far_model
`default_nettype wire

/* verilog/ufc_fifo_ctrl.sv */
// Purpose: Transmit/receive FIFOs, their control register and DMA ready pins
// Assumes: Serialiser and receiver run on mclk; no synchronisers needed
// Notes: Register reads answer one cycle after the read strobe
//
// Implementation choices: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module ufc_fifo_ctrl
  import ufc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Transmit side, towards the serialiser
  input wire logic tx_pop,
  output logic tx_valid,
  output logic [7:0] tx_data,
  // Receive side, from the deserialiser
  input wire logic rx_push,
  input wire logic [7:0] rx_char,
  output logic rx_space,
  // DMA handshake and interrupt
  output logic tx_dma_ready_n,
  output logic rx_dma_ready_n,
  output logic irq
);
  logic [7:0] ctrl_q, ctrl_d;
  logic [1:0] stat_q, stat_d, mask_q, mask_d;
  logic [7:0] rdata_q, rdata_d;
  logic irq_q, irq_d;
  logic [7:0] tx_mem [0:63];
  logic [7:0] rx_mem [0:63];
  logic [5:0] tx_wp_q, tx_wp_d, tx_rp_q, tx_rp_d;
  logic [5:0] rx_wp_q, rx_wp_d, rx_rp_q, rx_rp_d;
  logic [6:0] tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_valid_q, tx_valid_d, rx_space_q, rx_space_d;
  logic tx_rdy_n_q, tx_rdy_n_d, rx_rdy_n_q, rx_rdy_n_d;
  logic [6:0] cap, trig;
  logic mode1, ctrl_wr, refit, tx_flush, rx_flush;
  logic tx_push_ok, tx_pop_ok, rx_push_ok, rx_pop_ok;

  // Register port, FIFO pointers and pin states
  always_comb
  begin
    cap = ufc_cap(ctrl_q[BIT_FIFOS_EN], ctrl_q[BIT_DEEP]);
    trig = ufc_trig(ctrl_q[BIT_DEEP], ctrl_q[7:6]);
    mode1 = ctrl_q[BIT_FIFOS_EN] & ctrl_q[BIT_DMA_MODE];
    ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;
    // Changing enable or depth flushes too, so no count outlives a depth
    refit = ctrl_wr && (reg_wdata[BIT_FIFOS_EN] != ctrl_q[BIT_FIFOS_EN] ||
      reg_wdata[BIT_DEEP] != ctrl_q[BIT_DEEP]);
    tx_flush = (ctrl_wr && reg_wdata[BIT_TX_FLUSH]) || refit;
    rx_flush = (ctrl_wr && reg_wdata[BIT_RX_FLUSH]) || refit;
    // Flush bits and bit 4 are never stored, so they read back as zero
    ctrl_d = ctrl_wr ? (reg_wdata & CTRL_STORE_MASK) : ctrl_q;
    tx_push_ok = reg_wr && reg_addr == ADDR_HOLD && tx_cnt_q < cap;
    tx_pop_ok = tx_pop && tx_cnt_q != 7'h00;
    // Storing goes on past the trigger level until the FIFO is full
    rx_push_ok = rx_push && rx_cnt_q < cap;
    rx_pop_ok = reg_rd && reg_addr == ADDR_HOLD && rx_cnt_q != 7'h00;
    tx_wp_d = tx_wp_q + 6'(tx_push_ok);
    tx_rp_d = tx_rp_q + 6'(tx_pop_ok);
    tx_cnt_d = tx_cnt_q + 7'(tx_push_ok) - 7'(tx_pop_ok);
    rx_wp_d = rx_wp_q + 6'(rx_push_ok);
    rx_rp_d = rx_rp_q + 6'(rx_pop_ok);
    rx_cnt_d = rx_cnt_q + 7'(rx_push_ok) - 7'(rx_pop_ok);
    if (tx_flush)
    begin
      tx_wp_d = 6'h00;
      tx_rp_d = 6'h00;
      tx_cnt_d = 7'h00;
    end
    if (rx_flush)
    begin
      rx_wp_d = 6'h00;
      rx_rp_d = 6'h00;
      rx_cnt_d = 7'h00;
    end
    // Head of the transmit FIFO, bypassing a write into the same slot
    tx_data_d = (tx_push_ok && tx_wp_q == tx_rp_d) ? reg_wdata
                                                   : tx_mem[tx_rp_d];
    tx_valid_d = tx_cnt_d != 7'h00;
    rx_space_d = rx_cnt_d < cap;
    // Transmit ready pin
    if (!mode1)
      tx_rdy_n_d = tx_cnt_d != 7'h00;
    else if (tx_cnt_d == cap)
      tx_rdy_n_d = 1'b1;
    else if (tx_cnt_d == 7'h00)
      tx_rdy_n_d = 1'b0;
    else
      tx_rdy_n_d = tx_rdy_n_q;
    // Receive ready pin: in mode 1 it holds low from trigger until empty
    if (!mode1)
      rx_rdy_n_d = rx_cnt_d == 7'h00;
    else if (rx_cnt_d >= trig)
      rx_rdy_n_d = 1'b0;
    else if (rx_cnt_d == 7'h00)
      rx_rdy_n_d = 1'b1;
    else
      rx_rdy_n_d = rx_rdy_n_q;
    // Events: per character in mode 0, by level in mode 1; set beats clear
    stat_d = stat_q;
    if (reg_wr && reg_addr == ADDR_IRQ_STAT)
      stat_d = stat_q & ~reg_wdata[1:0];
    if (!mode1)
    begin
      if (rx_push_ok)
        stat_d[IRQ_RX] = 1'b1;
      if (tx_pop_ok)
        stat_d[IRQ_TX] = 1'b1;
    end
    else
    begin
      if (rx_cnt_q == trig)
        stat_d[IRQ_RX] = 1'b1;
      if (tx_cnt_q < trig)
        stat_d[IRQ_TX] = 1'b1;
    end
    mask_d = (reg_wr && reg_addr == ADDR_IRQ_MASK) ? reg_wdata[1:0] : mask_q;
    irq_d = |(stat_d & mask_d);
    // Read data stand for one cycle only
    rdata_d = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        ADDR_HOLD: rdata_d = rx_mem[rx_rp_q];
        ADDR_CTRL: rdata_d = ctrl_q;
        ADDR_IRQ_STAT: rdata_d = {6'h00, stat_q};
        ADDR_IRQ_MASK: rdata_d = {6'h00, mask_q};
        ADDR_RX_LEVEL: rdata_d = {1'b0, rx_cnt_q};
        ADDR_TX_LEVEL: rdata_d = {1'b0, tx_cnt_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= CTRL_RESET;
      stat_q <= IRQ_RESET;
      mask_q <= IRQ_RESET;
      irq_q <= 1'b0;
      rdata_q <= 8'h00;
      tx_wp_q <= 6'h00;
      tx_rp_q <= 6'h00;
      rx_wp_q <= 6'h00;
      rx_rp_q <= 6'h00;
      tx_cnt_q <= 7'h00;
      rx_cnt_q <= 7'h00;
      tx_data_q <= 8'h00;
      tx_valid_q <= 1'b0;
      rx_space_q <= 1'b1;
      tx_rdy_n_q <= 1'b0;
      rx_rdy_n_q <= 1'b1;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      rdata_q <= rdata_d;
      tx_wp_q <= tx_wp_d;
      tx_rp_q <= tx_rp_d;
      rx_wp_q <= rx_wp_d;
      rx_rp_q <= rx_rp_d;
      tx_cnt_q <= tx_cnt_d;
      rx_cnt_q <= rx_cnt_d;
      tx_data_q <= tx_data_d;
      tx_valid_q <= tx_valid_d;
      rx_space_q <= rx_space_d;
      tx_rdy_n_q <= tx_rdy_n_d;
      rx_rdy_n_q <= rx_rdy_n_d;
    end
  end

  // Storage has no reset; HOLD reads and tx_data show the head slot even when the FIFO is empty
  always_ff @(posedge mclk)
  begin
    if (tx_push_ok)
      tx_mem[tx_wp_q] <= reg_wdata;
    if (rx_push_ok)
      rx_mem[rx_wp_q] <= rx_char;
  end

  assign reg_rdata = rdata_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign rx_space = rx_space_q;
  assign tx_dma_ready_n = tx_rdy_n_q;
  assign rx_dma_ready_n = rx_rdy_n_q;
  assign irq = irq_q;

  sequence s_flush_write;
    reg_wr && reg_addr == ADDR_CTRL && reg_wdata[BIT_TX_FLUSH]
      && reg_wdata[BIT_RX_FLUSH];
  endsequence

  sequence s_both_empty;
    tx_cnt_q == 7'h00 && rx_cnt_q == 7'h00 && ctrl_q[2:1] == 2'h0;
  endsequence

  chk_flush_empties: assert property (@(posedge mclk) disable iff (rst)
    s_flush_write |=> s_both_empty)
    else $error("flush did not empty both FIFOs");

  chk_tx_rdy_mode0: assert property (@(posedge mclk) disable iff (rst)
    !mode1 && $stable(ctrl_q) |-> tx_rdy_n_q == (tx_cnt_q != 7'h00))
    else $error("tx ready wrong in mode 0");

  chk_rx_rdy_mode0: assert property (@(posedge mclk) disable iff (rst)
    !mode1 && $stable(ctrl_q) |-> rx_rdy_n_q == (rx_cnt_q == 7'h00))
    else $error("rx ready wrong in mode 0");

  chk_rx_rdy_trig: assert property (@(posedge mclk) disable iff (rst)
    mode1 && $stable(ctrl_q) && rx_cnt_q >= trig |-> !rx_rdy_n_q)
    else $error("rx ready high above trigger in mode 1");

  chk_tx_rdy_full: assert property (@(posedge mclk) disable iff (rst)
    mode1 && $stable(ctrl_q) && tx_cnt_q == cap |-> tx_rdy_n_q)
    else $error("tx ready low with full FIFO in mode 1");

  chk_rx_fill_on: assert property (@(posedge mclk) disable iff (rst)
    rx_push_ok && !rx_pop_ok && !rx_flush |=>
      rx_cnt_q == $past(rx_cnt_q) + 7'h01)
    else $error("received character not stored");

  chk_char_event: assert property (@(posedge mclk) disable iff (rst)
    !mode1 && rx_push_ok |=> stat_q[IRQ_RX] && (irq_q || !mask_q[IRQ_RX]))
    else $error("mode 0 receive event missing");

  chk_tx_char_event: assert property (@(posedge mclk) disable iff (rst)
    !mode1 && tx_pop_ok |=> stat_q[IRQ_TX] && (irq_q || !mask_q[IRQ_TX]))
    else $error("mode 0 transmit event missing");

  chk_tx_low_event: assert property (@(posedge mclk) disable iff (rst)
    mode1 && tx_cnt_q < trig |=> stat_q[IRQ_TX])
    else $error("mode 1 transmit event missing");

  chk_rx_trig_event: assert property (@(posedge mclk) disable iff (rst)
    mode1 && rx_cnt_q == trig |=> stat_q[IRQ_RX])
    else $error("mode 1 receive trigger event missing");

  chk_depth_limit: assert property (@(posedge mclk) disable iff (rst)
    $stable(ctrl_q) |-> rx_cnt_q <= cap && tx_cnt_q <= cap)
    else $error("FIFO count beyond selected depth");

  chk_reserved_zero: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[4] == 1'b0)
    else $error("reserved control bit stored");

  chk_deep_trigger: assert property (@(posedge mclk) disable iff (rst)
    ctrl_q[BIT_DEEP] && ctrl_q[7:6] == 2'h3 |-> trig == 7'h38)
    else $error("deep top trigger level wrong");

  chk_legacy_depth: assert property (@(posedge mclk) disable iff (rst)
    !ctrl_q[BIT_FIFOS_EN] && $stable(ctrl_q) |-> rx_cnt_q <= 7'h01)
    else $error("more than one character held with FIFOs off");

  chk_tx_rdy_empty: assert property (@(posedge mclk) disable iff (rst)
    mode1 && $stable(ctrl_q) && tx_cnt_q == 7'h00 |-> !tx_rdy_n_q)
    else $error("tx ready high with empty FIFO in mode 1");

  chk_tx_rdy_hold: assert property (@(posedge mclk) disable iff (rst)
    mode1 && tx_rdy_n_q |=> tx_rdy_n_q || tx_cnt_q == 7'h00)
    else $error("tx ready fell before FIFO emptied in mode 1");

  chk_rx_rdy_empty: assert property (@(posedge mclk) disable iff (rst)
    mode1 && $stable(ctrl_q) && rx_cnt_q == 7'h00 |-> rx_rdy_n_q)
    else $error("rx ready low with empty FIFO in mode 1");

  chk_rx_rdy_hold: assert property (@(posedge mclk) disable iff (rst)
    mode1 && !rx_rdy_n_q |=> !rx_rdy_n_q || rx_cnt_q == 7'h00)
    else $error("rx ready rose before FIFO emptied in mode 1");

  chk_rx_space_lvl: assert property (@(posedge mclk) disable iff (rst)
    $stable(ctrl_q) |-> rx_space_q == (rx_cnt_q < cap))
    else $error("rx space flag disagrees with fill level");
endmodule : ufc_fifo_ctrl
`default_nettype wire

/* verilog/ufc_pkg.sv */
// Purpose: Constants for the UART FIFO control and DMA ready block
// Assumes: One clock (mclk), registers on a plain strobe port
// Notes: How it works list below uses the block's own tags
package ufc_pkg;
  // Register indexes on the 3-bit address port
  localparam logic [2:0] ADDR_HOLD = 3'h0;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_IRQ_STAT = 3'h4;
  localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
  localparam logic [2:0] ADDR_RX_LEVEL = 3'h6;
  localparam logic [2:0] ADDR_TX_LEVEL = 3'h7;
  // Control register fields
  localparam int BIT_FIFOS_EN = 0;
  localparam int BIT_RX_FLUSH = 1;
  localparam int BIT_TX_FLUSH = 2;
  localparam int BIT_DMA_MODE = 3;
  localparam int BIT_DEEP = 5;
  localparam int BIT_TRIG_LO = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_STORE_MASK = 8'he9;
  // Interrupt status bits
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Depths and trigger levels
  localparam logic [6:0] DEPTH_NONE = 7'h01;
  localparam logic [6:0] DEPTH_SHALLOW = 7'h10;
  localparam logic [6:0] DEPTH_DEEP = 7'h40;
  localparam logic [6:0] TRIG_S0 = 7'h01;
  localparam logic [6:0] TRIG_S1 = 7'h04;
  localparam logic [6:0] TRIG_S2 = 7'h08;
  localparam logic [6:0] TRIG_S3 = 7'h0e;
  localparam logic [6:0] TRIG_D0 = 7'h01;
  localparam logic [6:0] TRIG_D1 = 7'h10;
  localparam logic [6:0] TRIG_D2 = 7'h20;
  localparam logic [6:0] TRIG_D3 = 7'h38;

  function automatic logic [6:0] ufc_trig(input logic deep,
                                          input logic [1:0] sel);
    logic [6:0] t;
    t = TRIG_S0;
    case (sel)
      2'h0: t = deep ? TRIG_D0 : TRIG_S0;
      2'h1: t = deep ? TRIG_D1 : TRIG_S1;
      2'h2: t = deep ? TRIG_D2 : TRIG_S2;
      default: t = deep ? TRIG_D3 : TRIG_S3;
    endcase
    return t;
  endfunction : ufc_trig

  function automatic logic [6:0] ufc_cap(input logic en, input logic deep);
    return !en ? DEPTH_NONE : (deep ? DEPTH_DEEP : DEPTH_SHALLOW);
  endfunction : ufc_cap
endpackage : ufc_pkg
